// >>> hw/cmb_msg_buffers.sv
// Message buffers, transmit scheduling and time stamping with a Wishbone slave.
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_consts.svh"

module cmb_msg_buffers #(
    parameter int NBUF = 3,
    parameter int TW   = 16
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ce_i,
    // Wishbone classic slave.
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [7:0]    adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic [31:0]        dat_o,
    output logic               ack_o,
    // Protocol engine side.
    input  wire logic          bit_tick_i,
    input  wire logic          sof_req_i,
    input  wire logic          tx_abandon_i,
    input  wire logic          eof_ok_i,
    input  wire logic          eof_tx_i,
    input  wire logic [2:0]    tx_byte_idx_i,
    input  wire logic          rx_wr_i,
    input  wire logic [3:0]    rx_idx_i,
    input  wire logic [7:0]    rx_data_i,
    output logic               tx_valid_o,
    output logic [1:0]         tx_buf_o,
    output logic [31:0]        tx_ident_o,
    output logic               tx_rtr_o,
    output logic               tx_ext_o,
    output logic [3:0]         tx_dlc_o,
    output logic [3:0]         tx_nbytes_o,
    output logic [7:0]         tx_byte_o,
    output logic [NBUF-1:0]    tx_empty_o,
    output logic               rx_full_o
);
    localparam int BW = $clog2(NBUF);

    // Byte count for a length code; remote frames carry none.
    function automatic logic [3:0] byte_count(input logic [3:0] dlc, input logic rtr);
        logic [3:0] n;
        n = (dlc > `CMB_MAX_BYTES) ? `CMB_MAX_BYTES : dlc;
        return rtr ? 4'h0 : n;
    endfunction

    // Index of the lowest set bit, used to address the selected buffer through the transmit window.
    function automatic logic [BW-1:0] lowest_set(input logic [NBUF-1:0] v);
        logic [BW-1:0] r;
        r = '0;
        for (int i = NBUF - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = BW'(i);
            end
        end
        return r;
    endfunction

    // Storage: transmit buffers, foreground and background receive buffers.
    logic [7:0]      txm_q [NBUF][`CMB_BUF_BYTES];
    logic [7:0]      priority_field_q [NBUF];
    logic [7:0]      rxf_q [`CMB_BUF_BYTES];
    logic [7:0]      rxb_q [`CMB_BUF_BYTES];
    logic [NBUF-1:0] txe_q;
    logic [NBUF-1:0] tsel_q;
    logic            init_q;
    logic            time_en_q;
    logic            rx_full_q;
    logic [TW-1:0]   timer_q;
    logic [BW-1:0]   act_q;
    cmb_pkg::cmb_tx_state_t state_q;

    // Bus decode.
    logic            req;
    logic            wr;
    logic [1:0]      win;
    logic [3:0]      idx;
    logic [BW-1:0]   sel_buf;
    logic            tx_access;
    logic            rx_stamp_ok;
    logic            pick_any;
    logic [BW-1:0]   pick_win;
    logic [NBUF*8-1:0] priority_field_flat;
    logic [NBUF-1:0] sw_sched;
    logic            tx_done;
    logic            rx_done;
    logic [3:0]      rx_limit;

    assign req       = cyc_i && stb_i && !ack_o;
    assign wr        = req && we_i && sel_i[0];
    assign win       = adr_i[7:6];
    assign idx       = adr_i[5:2];
    assign sel_buf   = lowest_set(tsel_q);
    // Window open only for selected empty buffer.
    assign tx_access = (tsel_q != '0) && txe_q[sel_buf];
    // Receive stamp readable only while full.
    assign rx_stamp_ok = rx_full_q;
    assign tx_done   = ce_i && eof_ok_i && eof_tx_i && (state_q == cmb_pkg::CMB_TX_ACTIVE);
    assign rx_done   = ce_i && eof_ok_i && !eof_tx_i;
    assign sw_sched  = (wr && win == `CMB_WIN_CTL && idx == `CMB_CTL_TX_EMPTY)
                       ? dat_i[NBUF-1:0] : '0;
    // Receive counts only bytes within the length.
    assign rx_limit  = byte_count(rxb_q[`CMB_IDX_LENGTH][3:0], rxb_q[`CMB_IDX_IDENT1][4]);

    genvar g;
    generate
        for (g = 0; g < NBUF; g++)
        begin : g_flat
            assign priority_field_flat[g*8 +: 8] = priority_field_q[g];
        end
    endgenerate

    // Buffers with empty flag cleared compete.
    cmb_priority_field_pick #(
        .NBUF (NBUF),
        .PW   (8)
    ) u_pick (
        .ready_i (~txe_q),
        .priority_field_i  (priority_field_flat),
        .any_o   (pick_any),
        .win_o   (pick_win)
    );

    // Wishbone answer: ack one cycle after the request, then low for a cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
        end
        else if (ce_i)
        begin
            ack_o <= req;
        end
    end

    // Read data mux; closed windows and unmapped addresses read as zero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_o <= 32'h0000_0000;
        end
        else if (ce_i && req)
        begin
            dat_o <= 32'h0000_0000;
            case (win)
                `CMB_WIN_TX:
                begin
                    if (tx_access)
                    begin
                        dat_o[7:0] <= (idx == `CMB_IDX_PRIORITY) ? priority_field_q[sel_buf]
                                                                  : txm_q[sel_buf][idx];
                    end
                end
                `CMB_WIN_RX:
                begin
                    if (idx < `CMB_IDX_STAMP_HIGH || rx_stamp_ok)
                    begin
                        dat_o[7:0] <= (idx == `CMB_IDX_PRIORITY) ? 8'h00 : rxf_q[idx];
                    end
                end
                `CMB_WIN_CTL:
                begin
                    case (idx)
                        `CMB_CTL_TX_EMPTY:  dat_o[NBUF-1:0] <= txe_q;
                        `CMB_CTL_TX_SELECT: dat_o[NBUF-1:0] <= tsel_q;
                        `CMB_CTL_MODE:      dat_o[1:0] <= {time_en_q, init_q};
                        `CMB_CTL_RX_STATUS: dat_o[0] <= rx_full_q;
                        default:            dat_o <= 32'h0000_0000;
                    endcase
                end
                default: dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Mode register; init mode is entered at reset.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            {time_en_q, init_q} <= 2'(`CMB_MODE_RESET);
        end
        else if (ce_i && wr && win == `CMB_WIN_CTL && idx == `CMB_CTL_MODE)
        begin
            init_q    <= dat_i[`CMB_MODE_INIT];
            time_en_q <= dat_i[`CMB_MODE_TIME];
        end
    end

    // Selection keeps only buffers that are empty at write time.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tsel_q <= '0;
        end
        else if (ce_i && wr && win == `CMB_WIN_CTL && idx == `CMB_CTL_TX_SELECT)
        begin
            tsel_q <= dat_i[NBUF-1:0] & txe_q;
        end
    end

    // Empty flags: writing one schedules a buffer; completion sets it again.
    // The set from a completed frame wins over a same-cycle software write.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            txe_q <= '1;
        end
        else if (ce_i)
        begin
            for (int i = 0; i < NBUF; i++)
            begin
                if (tx_done && act_q == BW'(i))
                begin
                    txe_q[i] <= 1'b1;
                end
                else if (sw_sched[i])
                begin
                    txe_q[i] <= 1'b0;
                end
            end
        end
    end

    // Timer advances on bit ticks, wraps silently.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_q <= '0;
        end
        else if (ce_i)
        begin
            if (init_q)
            begin
                timer_q <= '0;
            end
            else if (bit_tick_i)
            begin
                timer_q <= timer_q + TW'(1);
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < NBUF; i++)
            begin
                priority_field_q[i] <= `CMB_PRIORITY_FIELD_RESET;
            end
        end
        else if (ce_i && wr && win == `CMB_WIN_TX && tx_access && idx == `CMB_IDX_PRIORITY)
        begin
            priority_field_q[sel_buf] <= dat_i[7:0];
        end
    end

    // Transmit contents; software writes stop short of the stamp bytes.
    // Stamp bytes ignore writes.
    // Stamp written after valid transmit EOF.
    always_ff @(posedge clk_i)
    begin
        if (ce_i)
        begin
            if (wr && win == `CMB_WIN_TX && tx_access && idx <= `CMB_IDX_LENGTH)
            begin
                txm_q[sel_buf][idx] <= dat_i[7:0];
            end
            if (tx_done && time_en_q)
            begin
                txm_q[act_q][`CMB_IDX_STAMP_HIGH] <= timer_q[TW-1:TW-8];
                txm_q[act_q][`CMB_IDX_STAMP_LOW]  <= timer_q[7:0];
            end
        end
    end

    // Received remote flag stored as received.
    // Received extended flag stored as received.
    // Payload bytes beyond the length are dropped.
    always_ff @(posedge clk_i)
    begin
        if (ce_i && rx_wr_i)
        begin
            if (rx_idx_i < `CMB_IDX_PAYLOAD0 || rx_idx_i == `CMB_IDX_LENGTH
                || (rx_idx_i <= `CMB_IDX_PAYLOAD7 && rx_idx_i - `CMB_IDX_PAYLOAD0 < rx_limit))
            begin
                rxb_q[rx_idx_i] <= rx_data_i;
            end
        end
    end

    // Foreground copy on a valid receive while the foreground is free.
    // Receive stamp taken at valid EOF.
    always_ff @(posedge clk_i)
    begin
        if (rx_done && !rx_full_q)
        begin
            for (int i = 0; i < `CMB_BUF_BYTES; i++)
            begin
                rxf_q[i] <= rxb_q[i];
            end
            if (time_en_q)
            begin
                rxf_q[`CMB_IDX_STAMP_HIGH] <= timer_q[TW-1:TW-8];
                rxf_q[`CMB_IDX_STAMP_LOW]  <= timer_q[7:0];
            end
        end
    end

    // Receive-full flag: hardware set wins over a software write-one clear.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_full_q <= 1'b0;
        end
        else if (ce_i)
        begin
            if (rx_done && !rx_full_q)
            begin
                rx_full_q <= 1'b1;
            end
            else if (wr && win == `CMB_WIN_CTL && idx == `CMB_CTL_RX_STATUS
                     && dat_i[`CMB_RX_FULL_BIT])
            begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // Scheduler: pick at start of frame, release on EOF or lost arbitration.
    // Lowest priority value is chosen.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= cmb_pkg::CMB_TX_IDLE;
            act_q   <= '0;
        end
        else if (ce_i)
        begin
            case (state_q)
                cmb_pkg::CMB_TX_IDLE:
                begin
                    if (sof_req_i && pick_any)
                    begin
                        act_q   <= pick_win;
                        state_q <= cmb_pkg::CMB_TX_ACTIVE;
                    end
                end
                cmb_pkg::CMB_TX_ACTIVE:
                begin
                    if ((eof_ok_i && eof_tx_i) || tx_abandon_i)
                    begin
                        state_q <= cmb_pkg::CMB_TX_IDLE;
                    end
                end
                default: state_q <= cmb_pkg::CMB_TX_IDLE;
            endcase
        end
    end

    // Frame fields presented to the engine, loaded when a buffer wins.
    // Standard identifier from ident bytes 0 and 1.
    // Identifier word MSB is first on the wire.
    // Remote frame keeps code, sends zero bytes.
    // Byte counts for codes above eight clamp to eight.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_valid_o  <= 1'b0;
            tx_buf_o    <= 2'h0;
            tx_ident_o  <= 32'h0000_0000;
            tx_rtr_o    <= 1'b0;
            tx_ext_o    <= 1'b0;
            tx_dlc_o    <= 4'h0;
            tx_nbytes_o <= 4'h0;
        end
        else if (ce_i)
        begin
            if (state_q == cmb_pkg::CMB_TX_IDLE && sof_req_i && pick_any)
            begin
                tx_valid_o  <= 1'b1;
                tx_buf_o    <= 2'(pick_win);
                tx_ident_o  <= {txm_q[pick_win][0], txm_q[pick_win][1],
                                txm_q[pick_win][2], txm_q[pick_win][3]};
                tx_rtr_o    <= txm_q[pick_win][`CMB_IDX_IDENT1][`CMB_IDENT1_RTR];
                tx_ext_o    <= txm_q[pick_win][`CMB_IDX_IDENT1][`CMB_IDENT1_EXT];
                tx_dlc_o    <= txm_q[pick_win][`CMB_IDX_LENGTH][3:0];
                tx_nbytes_o <= byte_count(txm_q[pick_win][`CMB_IDX_LENGTH][3:0],
                                          txm_q[pick_win][`CMB_IDX_IDENT1][4]);
            end
            else if (state_q == cmb_pkg::CMB_TX_ACTIVE
                     && ((eof_ok_i && eof_tx_i) || tx_abandon_i))
            begin
                tx_valid_o <= 1'b0;
            end
        end
    end

    // Payload byte read port for the engine, one cycle of latency.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_byte_o <= 8'h00;
        end
        else if (ce_i)
        begin
            tx_byte_o <= txm_q[act_q][`CMB_IDX_PAYLOAD0 + {1'b0, tx_byte_idx_i}];
        end
    end

    // Status mirrors.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tx_empty_o <= '1;
            rx_full_o  <= 1'b0;
        end
        else if (ce_i)
        begin
            tx_empty_o <= txe_q;
            rx_full_o  <= rx_full_q;
        end
    end

    // Checks on scheduling, timer and register access.
    a_priority_field_reset_zero: assert property (@(posedge clk_i)
        rst_i |=> priority_field_q[0] == 8'h00) else $error("priority not zero after reset");
    a_pick_lowest: assert property (@(posedge clk_i) disable iff (rst_i)
        pick_any |-> (txe_q[0] || priority_field_q[pick_win] <= priority_field_q[0]))
        else $error("winner priority above buffer 0");
    a_tie_low_index: assert property (@(posedge clk_i) disable iff (rst_i)
        (!txe_q[0] && priority_field_q[0] == priority_field_q[pick_win]) |-> pick_win == '0)
        else $error("tie not given to lowest index");
    a_only_pending: assert property (@(posedge clk_i) disable iff (rst_i)
        pick_any |-> !txe_q[pick_win]) else $error("empty buffer picked");
    a_timer_init: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && init_q) |=> timer_q == '0) else $error("timer not cleared in init");
    a_timer_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !init_q && bit_tick_i) |=> timer_q == $past(timer_q) + TW'(1))
        else $error("timer did not advance");
    a_remote_nobytes: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_valid_o && tx_rtr_o) |-> tx_nbytes_o == 4'h0) else $error("remote frame bytes");
    a_length_clamp: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_valid_o |-> tx_nbytes_o <= 4'h8) else $error("byte count above eight");
    a_done_sets_empty: assert property (@(posedge clk_i) disable iff (rst_i)
        tx_done |=> txe_q[$past(act_q)]) else $error("empty flag not set on done");
    a_stamp_on_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (tx_done && time_en_q)
        |=> txm_q[$past(act_q)][`CMB_IDX_STAMP_LOW] == $past(timer_q[7:0]))
        else $error("transmit stamp not written");
    a_closed_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && req && !we_i && win == `CMB_WIN_TX && !tx_access) |=> dat_o == 32'h0)
        else $error("closed window read data");
endmodule
`default_nettype wire

// >>> shared/cmb_consts.svh
// Register indices, field positions and reset values of the message buffer block.
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH

// Register indices inside one buffer window; byte address is four times the index.
`define CMB_IDX_IDENT0     4'h0
`define CMB_IDX_IDENT1     4'h1
`define CMB_IDX_IDENT2     4'h2
`define CMB_IDX_IDENT3     4'h3
`define CMB_IDX_PAYLOAD0   4'h4
`define CMB_IDX_PAYLOAD7   4'hb
`define CMB_IDX_LENGTH     4'hc
`define CMB_IDX_PRIORITY   4'hd
`define CMB_IDX_STAMP_HIGH 4'he
`define CMB_IDX_STAMP_LOW  4'hf

// Window selection on word address bits [5:4].
`define CMB_WIN_TX         2'h0
`define CMB_WIN_RX         2'h1
`define CMB_WIN_CTL        2'h2

// Control registers inside the control window (low four word address bits).
`define CMB_CTL_TX_EMPTY   4'h0
`define CMB_CTL_TX_SELECT  4'h1
`define CMB_CTL_MODE       4'h2
`define CMB_CTL_RX_STATUS  4'h3

// Field positions.
`define CMB_IDENT1_RTR     4
`define CMB_IDENT1_EXT     3
`define CMB_MODE_INIT      0
`define CMB_MODE_TIME      1
`define CMB_RX_FULL_BIT    0

// Reset values and limits.
`define CMB_PRIORITY_FIELD_RESET     8'h00
`define CMB_MODE_RESET     8'h01
`define CMB_MAX_BYTES      4'h8
`define CMB_BUF_BYTES      16

`endif

// >>> shared/cmb_pkg.sv
// Types shared by the message buffer block.
package cmb_pkg;
    typedef enum logic [0:0]
    {
        CMB_TX_IDLE   = 1'b0,
        CMB_TX_ACTIVE = 1'b1
    } cmb_tx_state_t;
endpackage

// >>> hw/cmb_priority_field_pick.sv
// Local priority picker: lowest priority value wins, lowest index breaks ties.
`timescale 1ns/1ps
`default_nettype none
module cmb_priority_field_pick #(
    parameter int NBUF = 3,
    parameter int PW   = 8
) (
    input  wire logic [NBUF-1:0]      ready_i,
    input  wire logic [NBUF*PW-1:0]   priority_field_i,
    output logic                      any_o,
    output logic [$clog2(NBUF)-1:0]   win_o
);
    // Strict less-than keeps the earlier index on a tie.
    always_comb
    begin
        logic [PW-1:0] best;
        best  = '1;
        any_o = 1'b0;
        win_o = '0;
        for (int i = 0; i < NBUF; i++)
        begin
            if (ready_i[i] && (!any_o || priority_field_i[i*PW +: PW] < best))
            begin
                best  = priority_field_i[i*PW +: PW];
                win_o = ($clog2(NBUF))'(i);
                any_o = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/cmb_engine_model.sv
// Protocol engine stand-in that pulses frame events into the buffers.
`timescale 1ns/1ps
`default_nettype none
module cmb_engine_model (
    input  wire logic  clk_i,
    output logic       tick_o,
    output logic       sof_o,
    output logic       eof_o,
    output logic       eof_tx_o,
    output logic [2:0] bidx_o,
    output logic       rx_wr_o,
    output logic [3:0] rx_idx_o,
    output logic [7:0] rx_dat_o
);
    // Every line starts idle so no event is seen at time zero.
    initial
    begin
        tick_o = 1'b0;
        sof_o = 1'b0;
        eof_o = 1'b0;
        eof_tx_o = 1'b0;
        bidx_o = 3'h0;
        rx_wr_o = 1'b0;
        rx_idx_o = 4'h0;
        rx_dat_o = 8'h00;
    end

    // One-cycle pulse: 0 bit tick, 1 start of frame, 2 end of frame.
    task automatic ev(input int k, input logic tx);
        @(posedge clk_i);
        tick_o <= (k == 0);
        sof_o <= (k == 1);
        eof_o <= (k == 2);
        eof_tx_o <= tx;
        @(posedge clk_i);
        tick_o <= 1'b0;
        sof_o <= 1'b0;
        eof_o <= 1'b0;
    endtask

    // Received byte; data is inverted after so a stale byte never looks valid.
    task automatic rx(input logic [3:0] i, input logic [7:0] d);
        @(posedge clk_i);
        rx_wr_o <= 1'b1;
        rx_idx_o <= i;
        rx_dat_o <= d;
        @(posedge clk_i);
        rx_wr_o <= 1'b0;
        rx_dat_o <= ~d;
    endtask

    // Payload byte index for the active transmit buffer.
    task automatic pick(input logic [2:0] k);
        @(posedge clk_i);
        bidx_o <= k;
    endtask
endmodule
`default_nettype wire

// >>> tb/can_message_buffer_layout_tb.sv
// Self-checking bench for the message buffers and transmit scheduling.
`timescale 1ns/1ps
`default_nettype none
module can_message_buffer_layout_tb;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0;
    logic        ce_i = 1'b1;
    logic        tx_abandon_i = 1'b0;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        tick, sof, eof, eof_tx, rx_wr;
    logic [2:0]  bidx;
    logic [3:0]  rx_idx;
    logic [7:0]  rx_dat;
    logic        tx_valid_o, tx_rtr_o, tx_ext_o, rx_full_o;
    logic [1:0]  tx_buf_o;
    logic [31:0] tx_ident_o;
    logic [3:0]  tx_dlc_o, tx_nbytes_o;
    logic [7:0]  tx_byte_o, q;
    logic [2:0]  tx_empty_o;
    int          n_errors = 0;
    int          checks_done = 0;

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    cmb_msg_buffers #(.NBUF(3), .TW(16)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .bit_tick_i(tick), .sof_req_i(sof), .tx_abandon_i(tx_abandon_i),
        .eof_ok_i(eof), .eof_tx_i(eof_tx), .tx_byte_idx_i(bidx),
        .rx_wr_i(rx_wr), .rx_idx_i(rx_idx), .rx_data_i(rx_dat),
        .tx_valid_o(tx_valid_o), .tx_buf_o(tx_buf_o), .tx_ident_o(tx_ident_o),
        .tx_rtr_o(tx_rtr_o), .tx_ext_o(tx_ext_o), .tx_dlc_o(tx_dlc_o),
        .tx_nbytes_o(tx_nbytes_o), .tx_byte_o(tx_byte_o),
        .tx_empty_o(tx_empty_o), .rx_full_o(rx_full_o)
    );

    cmb_engine_model i_eng (
        .clk_i(clk_i), .tick_o(tick), .sof_o(sof), .eof_o(eof),
        .eof_tx_o(eof_tx), .bidx_o(bidx), .rx_wr_o(rx_wr),
        .rx_idx_o(rx_idx), .rx_dat_o(rx_dat)
    );

    // Counts every compare and reports a mismatch at once.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Classic single cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'h1;
        adr_i <= a;
        dat_i <= {24'h0, d};
        for (int n = 0; n < 20; n++)
        begin
            @(posedge clk_i);
            if (ack_o === 1'b1)
                break;
        end
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        sel_i <= 4'h0;
        if (ack_o !== 1'b1)
        begin
            n_errors++;
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        check(32'(q), 32'(e));
    endtask

    // Fills one buffer; payload byte k of buffer b holds 64*b+k.
    task automatic load(input int b, input logic [7:0] i0, i1, d, p);
        wr(8'h84, 8'(1 << b));
        wr(8'h00, i0);
        wr(8'h04, i1);
        for (int k = 0; k < 8; k++)
            wr(8'(16 + 4 * k), 8'(64 * b + k));
        wr(8'h30, d);
        wr(8'h34, p);
    endtask

    // Starts a frame and checks which buffer won and what it offers.
    task automatic txf(input int b, input logic [10:0] id, input logic r, x,
                       input logic [3:0] dlc, nb);
        i_eng.ev(1, 1'b0);
        @(negedge clk_i);
        check(32'(tx_valid_o), 32'h1);
        check(32'(tx_buf_o), 32'(b));
        check(32'(tx_ident_o[31:21]), 32'(id));
        check(32'(tx_rtr_o), 32'(r));
        check(32'(tx_ext_o), 32'(x));
        check(32'(tx_dlc_o), 32'(dlc));
        check(32'(tx_nbytes_o), 32'(nb));
    endtask

    // Valid end of own frame releases the buffer.
    task automatic txend(input int b);
        i_eng.ev(2, 1'b1);
        @(negedge clk_i);
        check(32'(tx_valid_o), 32'h0);
        @(negedge clk_i);
        check(32'(tx_empty_o[b]), 32'h1);
    endtask

    task automatic t_reset;
        @(negedge clk_i);
        check(32'(tx_empty_o), 32'h7);
        check(32'(rx_full_o), 32'h0);
        wr(8'h84, 8'h04);
        rd(8'h34, 8'h00);
    endtask

    // Ties on priority 3 go to buffer 1; a pending buffer is walled off.
    task automatic t_sched;
        repeat (3) i_eng.ev(0, 1'b0);
        wr(8'h88, 8'h02);
        load(0, 8'h12, 8'ha0, 8'h0c, 8'h05);
        load(1, 8'hff, 8'hf0, 8'h05, 8'h03);
        load(2, 8'h01, 8'h28, 8'h02, 8'h03);
        wr(8'h80, 8'h07);
        wr(8'h84, 8'h01);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h55);
        txf(1, 11'h7ff, 1'b1, 1'b0, 4'h5, 4'h0);
        // Lost arbitration keeps the buffer pending, so it wins again.
        @(posedge clk_i);
        tx_abandon_i <= 1'b1;
        @(posedge clk_i);
        tx_abandon_i <= 1'b0;
        @(negedge clk_i);
        check(32'(tx_valid_o), 32'h0);
        @(negedge clk_i);
        check(32'(tx_empty_o), 32'h0);
        txf(1, 11'h7ff, 1'b1, 1'b0, 4'h5, 4'h0);
        repeat (2) i_eng.ev(0, 1'b0);
        txend(1);
        txf(2, 11'h009, 1'b0, 1'b1, 4'h2, 4'h2);
        i_eng.pick(3'h1);
        @(posedge clk_i);
        @(negedge clk_i);
        check(32'(tx_byte_o), 32'h81);
        txend(2);
        txf(0, 11'h095, 1'b0, 1'b0, 4'hc, 4'h8);
        i_eng.pick(3'h7);
        @(posedge clk_i);
        @(negedge clk_i);
        check(32'(tx_byte_o), 32'h07);
        repeat (3) i_eng.ev(0, 1'b0);
        txend(0);
    endtask

    // Stamps count only ticks after init ended and cannot be written.
    task automatic t_stamp;
        wr(8'h84, 8'h01);
        rd(8'h3c, 8'h05);
        rd(8'h38, 8'h00);
        wr(8'h3c, 8'haa);
        rd(8'h3c, 8'h05);
        rd(8'h00, 8'h12);
        wr(8'h84, 8'h02);
        rd(8'h3c, 8'h02);
    endtask

    // A received frame is committed whole and stamped.
    task automatic t_rx;
        i_eng.rx(4'h0, 8'h9a);
        i_eng.rx(4'h1, 8'h48);
        i_eng.rx(4'hc, 8'h01);
        i_eng.rx(4'h4, 8'h77);
        i_eng.ev(2, 1'b0);
        @(negedge clk_i);
        @(negedge clk_i);
        check(32'(rx_full_o), 32'h1);
        rd(8'h44, 8'h48);
        rd(8'h50, 8'h77);
        rd(8'h7c, 8'h05);
        wr(8'h8c, 8'h01);
        rd(8'h7c, 8'h00);
        // A frame end seen while the clock enable is low must not commit.
        @(posedge clk_i);
        ce_i <= 1'b0;
        i_eng.ev(2, 1'b0);
        @(posedge clk_i);
        ce_i <= 1'b1;
        @(negedge clk_i);
        check(32'(rx_full_o), 32'h0);
    endtask

    // Reset for two cycles, then the scenarios in turn.
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_sched();
        t_stamp();
        t_rx();
        test_done();
    end
endmodule
`default_nettype wire
